/* File: hw/glut_defs.vh */
// glut_defs.vh - shared constants of the gamma table / dither / display output stage
// assumes: included once per design file, by bare name, with no other headers.
//
// Overview of operation
// RL1 - Each of red, green and blue has its own table that turns an 8-bit post-scaler code into 10 bits.
// RL2 - Every table entry is an ordinary writable word, so any curve (inverse gamma included) can be loaded.
// RL3 - A bypass control sends pixels around the tables, and the table contents then have no effect.
// RL4 - The tables are filled by software writes through the register port.
// RL5 - One table write lands in red, green, blue or all three tables with the same word.
// RL6 - The 10-bit result can be dithered down to 8 or 6 bits per channel before the output port.
// RL7 - Dithering spreads the dropped error over neighbouring pixels and over successive frames.
// RL8 - Dithering offers an ordered pattern and a random method; ordered is the recommended choice.
// RL9 - The output port carries RGB pixels either 18 or 24 bits wide.
// RL10 - The output port carries either one or two pixels per display clock.
// RL11 - Output pixels and timing change on one display clock edge and the panel samples on the other.
// RL12 - In two-pixel mode software must program an even number of pixels per line.
// RL13 - Each table has 256 entries indexed directly by the 8-bit input code.
// RL14 - With dithering off, the 10-bit value is truncated to the output depth by dropping its low bits.
`ifndef GLUT_DEFS_VH
`define GLUT_DEFS_VH

// register offsets (byte addresses)
`define GLUT_OFS_CTRL     8'h00
`define GLUT_OFS_LUT_IDX  8'h04
`define GLUT_OFS_LUT_DATA 8'h08
`define GLUT_OFS_STATUS   8'h0C

// control register fields
`define GLUT_CTRL_BYPASS  0
`define GLUT_CTRL_DITH_EN 1
`define GLUT_CTRL_RANDOM  2
`define GLUT_CTRL_BUS24   3
`define GLUT_CTRL_DOUBLE  4
`define GLUT_CTRL_W       5
`define GLUT_CTRL_RST     5'h01

// table index register fields: entry index and channel select
`define GLUT_IDX_LSB      0
`define GLUT_IDX_MSB      7
`define GLUT_SEL_LSB      8
`define GLUT_SEL_MSB      9
`define GLUT_SEL_RED      2'h0
`define GLUT_SEL_GREEN    2'h1
`define GLUT_SEL_BLUE     2'h2
`define GLUT_SEL_ALL      2'h3

// status register fields
`define GLUT_ST_LEVEL_LSB 0
`define GLUT_ST_EMPTY     8
`define GLUT_ST_FRAME_LSB 16

// random dither generator
`define GLUT_LFSR_SEED    16'hACE1
`define GLUT_LFSR_TAPS    16'hB400

// output fifo
`define GLUT_FIFO_DEPTH   8
`define GLUT_FIFO_AW      3

`endif

/* File: hw/glut_top.v */
// glut_top.v - gamma tables, dither and display output port, with its output fifo
// assumes: pixel stream and register port come from logic on CORE_CLK_IN;
// the panel samples on the rising edge of DISP_CLK_OUT.
//
// The register offsets and strobed register access were decided locally.
`include "glut_defs.vh"

module glut_fifo #(
   parameter W     = 27,
   parameter DEPTH = `GLUT_FIFO_DEPTH,
   parameter AW    = `GLUT_FIFO_AW
) (
   input  wire          clk_in,
   input  wire          rst_in,
   input  wire          in_valid_in,
   output wire          in_ready_out,
   input  wire [W-1:0]  in_data_in,
   output wire          out_valid_out,
   input  wire          out_ready_in,
   output wire [W-1:0]  out_data_out,
   output wire [AW:0]   level_out
);
   reg [W-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ff;
   reg [AW-1:0] rd_ff;
   reg [AW:0]   cnt_ff;
   wire         push = in_valid_in && in_ready_out;
   wire         pop  = out_valid_out && out_ready_in;

   assign in_ready_out  = (cnt_ff != DEPTH[AW:0]);
   assign out_valid_out = (cnt_ff != {(AW+1){1'b0}});
   assign out_data_out  = mem[rd_ff];
   assign level_out     = cnt_ff;

   always @(posedge clk_in) begin
      if (push) begin
         mem[wr_ff] <= in_data_in;
      end
   end

   always @(posedge clk_in) begin
      if (rst_in) begin
         wr_ff  <= {AW{1'b0}};
         rd_ff  <= {AW{1'b0}};
         cnt_ff <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ff <= (wr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ff + 1'b1;
         end
         if (pop) begin
            rd_ff <= (rd_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ff + 1'b1;
         end
         if (push && !pop) begin
            cnt_ff <= cnt_ff + 1'b1;
         end else if (pop && !push) begin
            cnt_ff <= cnt_ff - 1'b1;
         end
      end
   end
endmodule // glut_fifo

module glut_top #(
   parameter FIFO_DEPTH = `GLUT_FIFO_DEPTH,
   parameter FIFO_AW    = `GLUT_FIFO_AW
) (
   input  wire        CORE_CLK_IN,
   input  wire        SYS_RST_IN,
   input  wire [7:0]  REG_ADDR_IN,
   input  wire [31:0] REG_WDATA_IN,
   input  wire        REG_WR_IN,
   input  wire        REG_RD_IN,
   output reg  [31:0] REG_RDATA_OUT,
   input  wire        PIX_VALID_IN,
   output reg         PIX_READY_OUT,
   input  wire [23:0] PIX_RGB_IN,
   input  wire        PIX_DE_IN,
   input  wire        PIX_HS_IN,
   input  wire        PIX_VS_IN,
   output reg         DISP_CLK_OUT,
   output reg  [47:0] DISP_DATA_OUT,
   output reg         DISP_DE_OUT,
   output reg         DISP_HS_OUT,
   output reg         DISP_VS_OUT
);
   // fifo word: {vs, hs, de, packed 24-bit pixel lane}
   localparam FW = 27;

   reg [9:0] lut_red   [0:255];
   reg [9:0] lut_green [0:255];
   reg [9:0] lut_blue  [0:255];

   reg [`GLUT_CTRL_W-1:0] ctrl_ff;
   reg [7:0]  idx_ff;
   reg [1:0]  sel_ff;
   reg [10:0] xpos_ff;
   reg [1:0]  ypos_ff;
   reg [7:0]  frame_ff;
   reg        de_d_ff;
   reg        vs_d_ff;
   reg [15:0] lfsr_ff;
   reg        s1_v_ff;
   reg [7:0]  s1_in_ff [0:2];
   reg [9:0]  s1_lut_ff [0:2];
   reg [3:0]  s1_thr_ff;
   reg [2:0]  s1_sync_ff;
   reg        s2_v_ff;
   reg [FW-1:0] s2_word_ff;
   reg        hold_v_ff;
   reg [FW-1:0] hold_ff;

   wire                 bypass   = ctrl_ff[`GLUT_CTRL_BYPASS];
   wire                 dith_en  = ctrl_ff[`GLUT_CTRL_DITH_EN];
   wire                 random   = ctrl_ff[`GLUT_CTRL_RANDOM];
   wire                 bus24    = ctrl_ff[`GLUT_CTRL_BUS24];
   wire                 dbl      = ctrl_ff[`GLUT_CTRL_DOUBLE];
   wire                 accept   = PIX_VALID_IN && PIX_READY_OUT;
   wire                 f_in_rdy;
   wire                 f_out_v;
   wire [FW-1:0]        f_out;
   wire [FIFO_AW:0]     f_level;
   reg                  f_pop;
   reg  [FW-1:0]        nxt_word;
   reg  [3:0]           nxt_thr;
   reg  [9:0]           pre [0:2];
   reg  [4:0]           nxt_fill;
   integer              c;

   // 4x4 ordered threshold, 0..15
   function [3:0] bayer;
      input [1:0] x;
      input [1:0] y;
      begin
         bayer = {x[0] ^ y[0], y[0], x[1] ^ y[1], y[1]};
      end
   endfunction

   // add a threshold scaled to the dropped bits, saturating at full scale
   function [9:0] dith_add;
      input [9:0] v;
      input [3:0] t;
      input       drop4;
      reg   [10:0] s;
      begin
         s = {1'b0, v} + (drop4 ? {7'h00, t} : {9'h000, t[3:2]});
         dith_add = s[10] ? 10'h3FF : s[9:0];
      end
   endfunction

   // register port: writes and table loading
   always @(posedge CORE_CLK_IN) begin
      if (SYS_RST_IN) begin
         ctrl_ff <= `GLUT_CTRL_RST;
         idx_ff  <= 8'h00;
         sel_ff  <= `GLUT_SEL_RED;
      end else if (REG_WR_IN) begin
         case (REG_ADDR_IN)
            `GLUT_OFS_CTRL: begin
               ctrl_ff <= REG_WDATA_IN[`GLUT_CTRL_W-1:0];
            end
            `GLUT_OFS_LUT_IDX: begin
               idx_ff <= REG_WDATA_IN[`GLUT_IDX_MSB:`GLUT_IDX_LSB];
               sel_ff <= REG_WDATA_IN[`GLUT_SEL_MSB:`GLUT_SEL_LSB];
            end
            // RL4 host loads entry
            `GLUT_OFS_LUT_DATA: begin
               idx_ff <= idx_ff + 8'h01;
            end
            default: begin
               idx_ff <= idx_ff;
            end
         endcase
      end
   end

   // RL2 RL5 entry write per channel
   always @(posedge CORE_CLK_IN) begin
      if (REG_WR_IN && REG_ADDR_IN == `GLUT_OFS_LUT_DATA) begin
         if (sel_ff == `GLUT_SEL_RED || sel_ff == `GLUT_SEL_ALL) begin
            lut_red[idx_ff] <= REG_WDATA_IN[9:0];
         end
         if (sel_ff == `GLUT_SEL_GREEN || sel_ff == `GLUT_SEL_ALL) begin
            lut_green[idx_ff] <= REG_WDATA_IN[9:0];
         end
         if (sel_ff == `GLUT_SEL_BLUE || sel_ff == `GLUT_SEL_ALL) begin
            lut_blue[idx_ff] <= REG_WDATA_IN[9:0];
         end
      end
   end

   // read data stands only in the cycle after the strobe
   always @(posedge CORE_CLK_IN) begin
      if (SYS_RST_IN || !REG_RD_IN) begin
         REG_RDATA_OUT <= 32'h0000_0000;
      end else begin
         case (REG_ADDR_IN)
            `GLUT_OFS_CTRL: begin
               REG_RDATA_OUT <= {27'h0000000, ctrl_ff};
            end
            `GLUT_OFS_LUT_IDX: begin
               REG_RDATA_OUT <= {22'h000000, sel_ff, idx_ff};
            end
            `GLUT_OFS_STATUS: begin
               REG_RDATA_OUT <= {8'h00, frame_ff, 7'h00, ~f_out_v,
                                 {(8-FIFO_AW-1){1'b0}}, f_level};
            end
            default: begin
               REG_RDATA_OUT <= 32'h0000_0000;
            end
         endcase
      end
   end

   // RL7 pixel position and frame count for the dither pattern
   always @(posedge CORE_CLK_IN) begin
      if (SYS_RST_IN) begin
         xpos_ff  <= 11'h000;
         ypos_ff  <= 2'h0;
         frame_ff <= 8'h00;
         de_d_ff  <= 1'b0;
         vs_d_ff  <= 1'b0;
         lfsr_ff  <= `GLUT_LFSR_SEED;
      end else if (accept) begin
         de_d_ff <= PIX_DE_IN;
         vs_d_ff <= PIX_VS_IN;
         xpos_ff <= PIX_DE_IN ? xpos_ff + 11'h001 : 11'h000;
         if (PIX_VS_IN && !vs_d_ff) begin
            frame_ff <= frame_ff + 8'h01;
            ypos_ff  <= 2'h0;
         end else if (de_d_ff && !PIX_DE_IN) begin
            ypos_ff <= ypos_ff + 2'h1;
         end
         lfsr_ff <= lfsr_ff[0] ? ((lfsr_ff >> 1) ^ `GLUT_LFSR_TAPS) : (lfsr_ff >> 1);
      end
   end

   // RL8 ordered pattern shifted per frame, or random
   always @* begin
      if (random) begin
         nxt_thr = lfsr_ff[3:0];
      end else begin
         nxt_thr = bayer(xpos_ff[1:0] ^ frame_ff[1:0], ypos_ff ^ {frame_ff[0], frame_ff[1]});
      end
   end

   // stage 1: table lookup; RL1 RL13 direct 8-bit index
   always @(posedge CORE_CLK_IN) begin
      if (SYS_RST_IN) begin
         s1_v_ff    <= 1'b0;
         s1_thr_ff  <= 4'h0;
         s1_sync_ff <= 3'h0;
      end else begin
         s1_v_ff    <= accept;
         s1_thr_ff  <= dith_en ? nxt_thr : 4'h0;
         s1_sync_ff <= {PIX_VS_IN, PIX_HS_IN, PIX_DE_IN};
      end
   end

   always @(posedge CORE_CLK_IN) begin
      s1_in_ff[0]  <= PIX_RGB_IN[23:16];
      s1_in_ff[1]  <= PIX_RGB_IN[15:8];
      s1_in_ff[2]  <= PIX_RGB_IN[7:0];
      s1_lut_ff[0] <= lut_red[PIX_RGB_IN[23:16]];
      s1_lut_ff[1] <= lut_green[PIX_RGB_IN[15:8]];
      s1_lut_ff[2] <= lut_blue[PIX_RGB_IN[7:0]];
   end

   // stage 2: dither and pack into the output lane
   always @* begin
      for (c = 0; c < 3; c = c + 1) begin
         // RL3 bypass skips the table
         pre[c] = bypass ? {s1_in_ff[c], 2'b00} : s1_lut_ff[c];
         // RL6 RL14 add threshold, then drop low bits
         pre[c] = dith_add(pre[c], s1_thr_ff, !bus24);
      end
      // RL9 18-bit lane keeps 6 bits per colour in the low bits
      if (bus24) begin
         nxt_word = {s1_sync_ff, pre[0][9:2], pre[1][9:2], pre[2][9:2]};
      end else begin
         nxt_word = {s1_sync_ff, 6'h00, pre[0][9:4], pre[1][9:4], pre[2][9:4]};
      end
   end

   always @(posedge CORE_CLK_IN) begin
      if (SYS_RST_IN) begin
         s2_v_ff    <= 1'b0;
         s2_word_ff <= {FW{1'b0}};
      end else begin
         s2_v_ff    <= s1_v_ff;
         s2_word_ff <= nxt_word;
      end
   end

   // ready leaves room for the two words still in the pipeline
   always @* begin
      nxt_fill = {{(4-FIFO_AW){1'b0}}, f_level} + {4'h0, s1_v_ff} + {4'h0, s2_v_ff}
                 + {4'h0, accept};
   end

   always @(posedge CORE_CLK_IN) begin
      if (SYS_RST_IN) begin
         PIX_READY_OUT <= 1'b0;
      end else begin
         PIX_READY_OUT <= (nxt_fill <= FIFO_DEPTH - 2);
      end
   end

   glut_fifo #(
      .W     (FW),
      .DEPTH (FIFO_DEPTH),
      .AW    (FIFO_AW)
   ) u_fifo (
      .clk_in        (CORE_CLK_IN),
      .rst_in        (SYS_RST_IN),
      .in_valid_in   (s2_v_ff),
      .in_ready_out  (f_in_rdy),
      .in_data_in    (s2_word_ff),
      .out_valid_out (f_out_v),
      .out_ready_in  (f_pop),
      .out_data_out  (f_out),
      .level_out     (f_level)
   );

   // drain: single mode one word per display clock, double mode a pair
   always @* begin
      if (dbl) begin
         f_pop = DISP_CLK_OUT ? (hold_v_ff && f_out_v) : (!hold_v_ff && f_out_v);
      end else begin
         f_pop = DISP_CLK_OUT && f_out_v;
      end
   end

   // RL11 outputs change as the display clock falls; panel samples on its rise
   always @(posedge CORE_CLK_IN) begin
      if (SYS_RST_IN) begin
         DISP_CLK_OUT  <= 1'b0;
         DISP_DATA_OUT <= 48'h0000_0000_0000;
         DISP_DE_OUT   <= 1'b0;
         DISP_HS_OUT   <= 1'b0;
         DISP_VS_OUT   <= 1'b0;
         hold_v_ff     <= 1'b0;
         hold_ff       <= {FW{1'b0}};
      end else begin
         DISP_CLK_OUT <= ~DISP_CLK_OUT;
         if (!dbl) begin
            hold_v_ff <= 1'b0;
         end else if (!DISP_CLK_OUT && f_pop) begin
            hold_v_ff <= 1'b1;
            hold_ff   <= f_out;
         end else if (DISP_CLK_OUT && f_pop) begin
            hold_v_ff <= 1'b0;
         end
         if (DISP_CLK_OUT) begin
            if (f_pop && dbl) begin
               // RL10 RL12 first pixel low lane, second high lane
               DISP_DATA_OUT <= {f_out[23:0], hold_ff[23:0]};
               {DISP_VS_OUT, DISP_HS_OUT, DISP_DE_OUT} <= hold_ff[26:24];
            end else if (f_pop) begin
               // RL10 one pixel per clock
               DISP_DATA_OUT <= {24'h000000, f_out[23:0]};
               {DISP_VS_OUT, DISP_HS_OUT, DISP_DE_OUT} <= f_out[26:24];
            end else begin
               // starved: blank the data, keep sync levels
               DISP_DATA_OUT <= 48'h0000_0000_0000;
               DISP_DE_OUT   <= 1'b0;
            end
         end
      end
   end
endmodule // glut_top

/* File: test/glut_checker_properties.sv */
// glut_checker_properties.sv - concurrent checks on the glut_top ports
// assumes: bound into glut_top; offsets and reset control word from glut_defs.vh
`include "glut_defs.vh"
module glut_checker (
   input wire        CORE_CLK_IN,
   input wire        SYS_RST_IN,
   input wire [7:0]  REG_ADDR_IN,
   input wire [31:0] REG_WDATA_IN,
   input wire        REG_WR_IN,
   input wire        REG_RD_IN,
   input wire [31:0] REG_RDATA_OUT,
   input wire        DISP_CLK_OUT,
   input wire [47:0] DISP_DATA_OUT,
   input wire        DISP_DE_OUT,
   input wire        DISP_HS_OUT,
   input wire        DISP_VS_OUT
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [4:0] ctrl_ff;
   default clocking @(posedge CORE_CLK_IN); endclocking
   default disable iff (SYS_RST_IN);
   // shadow of the control word so lane checks know the mode
   always @(posedge CORE_CLK_IN) begin
      if (SYS_RST_IN) begin
         ctrl_ff <= `GLUT_CTRL_RST;
      end else if (REG_WR_IN && REG_ADDR_IN == `GLUT_OFS_CTRL) begin
         ctrl_ff <= REG_WDATA_IN[4:0];
      end
   end
   rdata_idle_a: assert property (!$past(REG_RD_IN) |-> REG_RDATA_OUT == 32'h0)
      else $error("read data not zero outside the answer cycle");
   ctrl_read_a: assert property (REG_RD_IN && REG_ADDR_IN == `GLUT_OFS_CTRL
      |=> REG_RDATA_OUT[4:0] == ctrl_ff) else $error("control read back wrong");
   unmapped_read_a: assert property (REG_RD_IN && REG_ADDR_IN != `GLUT_OFS_CTRL
      && REG_ADDR_IN != `GLUT_OFS_LUT_IDX && REG_ADDR_IN != `GLUT_OFS_STATUS
      |=> REG_RDATA_OUT == 32'h0) else $error("unmapped read not zero");
   disp_clk_run_a: assert property (!$past(SYS_RST_IN) |-> DISP_CLK_OUT != $past(DISP_CLK_OUT))
      else $error("display clock did not toggle");
   data_sync_a: assert property ($changed(DISP_DATA_OUT) |-> $fell(DISP_CLK_OUT))
      else $error("pixel data changed off the falling display clock");
   flag_sync_a: assert property ($changed({DISP_DE_OUT, DISP_HS_OUT, DISP_VS_OUT})
      |-> $fell(DISP_CLK_OUT)) else $error("timing flags changed off the falling clock");
   lane_narrow_a: assert property (!ctrl_ff[3] |-> DISP_DATA_OUT[23:18] == 6'h0
      && DISP_DATA_OUT[47:42] == 6'h0) else $error("18-bit lane has upper bits set");
   single_lane_a: assert property (!ctrl_ff[4] |-> DISP_DATA_OUT[47:24] == 24'h0)
      else $error("second lane active in single mode");
endmodule // glut_checker

/* File: test/glut_panel.sv */
// glut_panel.sv - display device model: samples the output port on the rising display clock
// assumes: driven from glut_top outputs; the bench reads and clears the captured words
module glut_panel (
   input wire        disp_clk_in,
   input wire [47:0] disp_data_in,
   input wire        disp_de_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [47:0] got[$];
   always @(posedge disp_clk_in) begin
      if (disp_de_in === 1'b1) begin
         got.push_back(disp_data_in);
      end
   end
endmodule // glut_panel

/* File: test/test_gamma_lut_dither_output.sv */
// test_gamma_lut_dither_output.sv - self-checking bench for glut_top and a panel model
// assumes: glut_top, glut_panel and glut_checker compiled first; 20 MHz core clock
`include "glut_defs.vh"
module test_gamma_lut_dither_output;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [4:0] c; logic [23:0] p; logic [47:0] e;} row_t;
   logic        clk, rst, wr, rd, pv, prdy, pde, phs, pvs, disp_clk, dde, dhs, dvs, saw_full;
   logic [7:0]  addr, fld;
   logic [31:0] wdata, rdata, rv;
   logic [23:0] prgb;
   logic [47:0] ddata;
   int          err_total, n_checks, lo, hi;
   row_t        rows[5];
   glut_top u_glut_top (.CORE_CLK_IN(clk), .SYS_RST_IN(rst), .REG_ADDR_IN(addr),
      .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
      .PIX_VALID_IN(pv), .PIX_READY_OUT(prdy), .PIX_RGB_IN(prgb), .PIX_DE_IN(pde),
      .PIX_HS_IN(phs), .PIX_VS_IN(pvs), .DISP_CLK_OUT(disp_clk), .DISP_DATA_OUT(ddata),
      .DISP_DE_OUT(dde), .DISP_HS_OUT(dhs), .DISP_VS_OUT(dvs));
   glut_panel u_glut_panel (.disp_clk_in(disp_clk), .disp_data_in(ddata), .disp_de_in(dde));
   task automatic chk(input string n, input logic [47:0] s, input logic [47:0] e);
      n_checks++;
      if (s !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask
   // valid stays up across pixels, so the fifo fills at full input rate
   task automatic burst(input logic [23:0] a, input logic [23:0] b, input int n);
      @(posedge clk);
      pv <= 1'b1;
      pde <= 1'b1;
      prgb <= a;
      for (int k = 1; k <= n; k++) begin
         do @(negedge clk); while (prdy !== 1'b1);
         @(posedge clk);
         prgb <= k[0] ? b : a;
         if (k == n) pv <= 1'b0;
      end
   endtask
   task automatic getn(input int n);
      int k;
      k = 0;
      while (u_glut_panel.got.size() < n && k < 400) begin
         @(posedge clk);
         k++;
      end
      repeat (4) @(posedge clk);
      chk("words", u_glut_panel.got.size(), n);
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(negedge clk) begin
      if (pv === 1'b1 && prdy === 1'b0) saw_full = 1'b1;
   end
   initial begin
      repeat (10000) @(posedge clk);
      err_total++;
      close_out();
   end
   initial begin
      rst = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 32'h0;
      pv = 1'b0;
      pde = 1'b0;
      phs = 1'b0;
      pvs = 1'b0;
      prgb = 24'h0;
      saw_full = 1'b0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rreg(`GLUT_OFS_CTRL, rv);
      chk("ctrl_rst", rv, 48'h1);
      rreg(8'h10, rv);
      chk("unmapped", rv, 48'h0);
      // inverted curve in all three tables at once; low bits set to expose truncation
      wreg(`GLUT_OFS_LUT_IDX, {22'h0, `GLUT_SEL_ALL, 8'h00});
      for (int i = 0; i < 256; i++) wreg(`GLUT_OFS_LUT_DATA, 32'h3FF ^ {i[7:0], 2'h0});
      // expected lanes: bypass {in,00} or inverted table, top 8 or 6 bits kept
      rows = '{'{5'h01, 24'hFF8040, 48'h3F810}, '{5'h09, 24'h123456, 48'h123456},
               '{5'h08, 24'h102030, 48'hEFDFCF}, '{5'h00, 24'h102030, 48'h3BDF3},
               '{5'h00, 24'h00FF80, 48'h3F01F}};
      foreach (rows[i]) begin
         wreg(`GLUT_OFS_CTRL, {27'h0, rows[i].c});
         u_glut_panel.got.delete();
         burst(rows[i].p, rows[i].p, 1);
         getn(1);
         chk("row", u_glut_panel.got[0], rows[i].e);
      end
      for (int i = 0; i < 3; i++) begin
         wreg(`GLUT_OFS_LUT_IDX, {22'h0, i[1:0], 8'h55});
         wreg(`GLUT_OFS_LUT_DATA, {22'h0, i[1:0] + 2'h1, 8'h00});
      end
      wreg(`GLUT_OFS_CTRL, 32'h08);
      u_glut_panel.got.delete();
      burst(24'h555555, 24'h555555, 1);
      getn(1);
      chk("chan", u_glut_panel.got[0], 48'h4080C0);
      rreg(`GLUT_OFS_LUT_IDX, rv);
      chk("idx_step", rv, 48'h256);
      wreg(`GLUT_OFS_CTRL, 32'h19);
      u_glut_panel.got.delete();
      burst(24'hA1B2C3, 24'h0D1E2F, 2);
      getn(1);
      chk("double", u_glut_panel.got[0], 48'h0D1E2FA1B2C3);
      // 18-bit ordered, 18-bit random, then 24-bit ordered through the table
      for (int j = 0; j < 3; j++) begin
         wreg(`GLUT_OFS_CTRL, (j == 0) ? 32'h03 : (j == 1) ? 32'h07 : 32'h0A);
         u_glut_panel.got.delete();
         lo = 0;
         hi = 0;
         saw_full = 1'b0;
         burst(24'h434343, 24'h434343, 16);
         getn(16);
         foreach (u_glut_panel.got[k]) begin
            fld = (j == 2) ? u_glut_panel.got[k][23:16] : {2'h0, u_glut_panel.got[k][17:12]};
            if (fld === ((j == 2) ? 8'hBC : 8'h10)) lo++;
            if (fld === ((j == 2) ? 8'hBD : 8'h11)) hi++;
         end
         chk("dith_range", lo + hi, 16);
         chk("dith_spread", lo > 0 && hi > 0, 1);
         chk("fifo_full", saw_full, 1);
      end
      // flags travel with their pixel; a rising vsync counts a frame
      phs <= 1'b1;
      pvs <= 1'b1;
      u_glut_panel.got.delete();
      burst(24'h434343, 24'h434343, 1);
      getn(1);
      chk("sync_flags", {dhs, dvs}, 48'h3);
      rreg(`GLUT_OFS_STATUS, rv);
      chk("status", rv, 48'h0001_0100);
      // reset in mid-run clears outputs and frame count, and returns control to its reset value 01
      @(posedge clk);
      phs <= 1'b0;
      pvs <= 1'b0;
      rst <= 1'b1;
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk("rst_flags", {prdy, disp_clk, dde, dhs, dvs}, 48'h0);
      chk("rst_data", ddata, 48'h0);
      @(posedge clk);
      rst <= 1'b0;
      rreg(`GLUT_OFS_CTRL, rv);
      chk("ctrl_rst2", rv, 48'h1);
      rreg(`GLUT_OFS_STATUS, rv);
      chk("status_rst", rv, 48'h100);
      close_out();
   end
endmodule // test_gamma_lut_dither_output
bind glut_top glut_checker u_glut_checker (.CORE_CLK_IN(CORE_CLK_IN), .SYS_RST_IN(SYS_RST_IN),
   .REG_ADDR_IN(REG_ADDR_IN), .REG_WDATA_IN(REG_WDATA_IN), .REG_WR_IN(REG_WR_IN),
   .REG_RD_IN(REG_RD_IN), .REG_RDATA_OUT(REG_RDATA_OUT), .DISP_CLK_OUT(DISP_CLK_OUT),
   .DISP_DATA_OUT(DISP_DATA_OUT), .DISP_DE_OUT(DISP_DE_OUT), .DISP_HS_OUT(DISP_HS_OUT),
   .DISP_VS_OUT(DISP_VS_OUT));
